/* rtl/peripheral_dma_channel_pair.sv */
// DMA channel pair serving one serial peripheral: APB register file,
// receive and transmit engines with current/next buffer chaining.
// Assumes rx_ready/tx_ready and mode come from logic on mclk, and that the
// bus matrix holds mem_grant high one cycle when it performs the access.
// Counters are CNT_W bits wide and read back zero-extended to a full word.
// Only one unit is in flight at a time, so receive and transmit never overlap.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module peripheral_dma_channel_pair #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dma_pkg::APB_AW-1:0] paddr,
  input wire logic [dma_pkg::DATA_W-1:0] pwdata,
  output logic [dma_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dma_pkg::served_peripheral_prefix_mode_type mode,
  input wire logic rx_ready,
  input wire logic [dma_pkg::DATA_W-1:0] rx_hold_data,
  output logic rx_hold_take,
  input wire logic tx_ready,
  output logic [dma_pkg::DATA_W-1:0] tx_hold_data,
  output logic tx_hold_load,
  output dma_pkg::flags_type flags,
  output dma_pkg::mem_req_type mem_req,
  input wire logic mem_grant,
  input wire logic [dma_pkg::DATA_W-1:0] mem_rdata
);
  import dma_pkg::*;

  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);

  typedef enum logic [1:0] {ST_IDLE, ST_RX_STORE, ST_TX_FETCH} engine_type;

  // Storage slot for an address; half duplex folds transmit onto receive
  // so both views of a shared register reach the same flip-flops
  function automatic logic [1:0] reg_slot(input logic [APB_AW-1:0] a, input logic hd);
    logic [1:0] s;
    s = a[SLOT_MSB:SLOT_LSB];
    if (hd) begin
      s[0] = 1'b0;
    end
    return s;
  endfunction : reg_slot

  // Pointer increment for a unit size
  // An unused size code steps like a byte rather than stalling the pointer
  function automatic logic [31:0] unit_step(input unit_type u);
    logic [31:0] st;
    st = STEP_BYTE;
    case (u)
      UNIT_BYTE: st = STEP_BYTE;
      UNIT_HALF: st = STEP_HALF;
      UNIT_WORD: st = STEP_WORD;
      default: st = STEP_BYTE;
    endcase
    return st;
  endfunction : unit_step

  logic [31:0] ptr_q [SLOT_NUM];
  logic [CNT_W-1:0] cnt_q [SLOT_NUM];
  logic rx_en_q;
  logic tx_en_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  engine_type state_q;
  logic [1:0] cur_q;
  logic [1:0] nxt_q;
  unit_type unit_q;
  mem_req_type mem_req_q;
  logic rx_take_q;
  logic tx_load_q;
  logic [31:0] tx_data_q;
  flags_type flags_q;

  logic setup;
  logic access;
  logic slot_hit;
  logic mapped;
  logic reg_wr;
  logic ctl_wr;
  logic [1:0] wr_slot;
  logic wr_cnt_nz;
  logic clr_rx_end;
  logic clr_tx_side;
  logic [31:0] rd_value;
  logic hd;
  logic [1:0] rx_cur;
  logic [1:0] rx_nxt;
  logic [1:0] tx_cur;
  logic [1:0] tx_nxt;
  logic rx_go;
  logic tx_go;
  logic unit_done;
  logic reach_zero;
  logic stop_now;
  logic done_rx;
  logic done_tx;

  // APB phase and address decode
  // Writes land only in the access phase, so a refused setup changes nothing
  assign setup = psel & ~penable;
  assign access = psel & penable & pready_q;
  assign slot_hit = (paddr >= OFS_RX_PTR) && (paddr <= OFS_TX_NCNT);
  assign mapped = (slot_hit || paddr == OFS_CTL || paddr == OFS_STATE) && (paddr[1:0] == 2'h0);
  assign hd = mode.half_duplex;
  assign wr_slot = reg_slot(paddr, hd);
  assign reg_wr = access & pwrite & ~pslverr_q & slot_hit;
  assign ctl_wr = access & pwrite & ~pslverr_q & (paddr == OFS_CTL);
  assign wr_cnt_nz = reg_wr & paddr[KIND_BIT] & (pwdata[CNT_W-1:0] != CNT_ZERO);
  // Nonzero count writes: receive side clears receive end, transmit side the rest
  assign clr_rx_end = wr_cnt_nz & (hd | ~paddr[SLOT_LSB]);
  assign clr_tx_side = wr_cnt_nz & (hd | paddr[SLOT_LSB]);

  // Register read mux
  // The control register is write-only and reads back as zero
  always_comb begin
    rd_value = RESET_WORD;
    if (slot_hit) begin
      if (paddr[KIND_BIT]) begin
        rd_value = {{(32-CNT_W){1'b0}}, cnt_q[wr_slot]};
      end else begin
        rd_value = ptr_q[wr_slot];
      end
    end else if (paddr == OFS_STATE) begin
      rd_value[STS_RX_EN] = rx_en_q;
      rd_value[STS_TX_EN] = tx_en_q;
      rd_value[STS_END_RX] = flags_q.end_rx;
      rd_value[STS_END_TX] = flags_q.end_tx;
      rd_value[STS_RX_FULL] = flags_q.rx_full;
      rd_value[STS_TX_EMPTY] = flags_q.tx_empty;
    end
  end

  // APB answer: ready in the access phase, error on unmapped addresses
  // Read data is zero outside the answer cycle to keep the bus quiet
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= RESET_WORD;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q <= (setup & ~pwrite) ? rd_value : RESET_WORD;
    end
  end

  // Channel enables; disable beats enable in the same write
  // A unit already in flight finishes even if its channel is switched off
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
    end else if (ctl_wr) begin
      if (pwdata[CTL_RX_OFF]) begin
        rx_en_q <= 1'b0;
      end else if (pwdata[CTL_RX_ON]) begin
        rx_en_q <= 1'b1;
      end
      if (pwdata[CTL_TX_OFF]) begin
        tx_en_q <= 1'b0;
      end else if (pwdata[CTL_TX_ON]) begin
        tx_en_q <= 1'b1;
      end
    end
  end

  // Slots each direction works on; half duplex shares the receive pair
  // The peripheral's mode then decides which direction may run
  assign rx_cur = SLOT_RX_CUR;
  assign rx_nxt = SLOT_RX_NXT;
  assign tx_cur = hd ? SLOT_RX_CUR : SLOT_TX_CUR;
  assign tx_nxt = hd ? SLOT_RX_NXT : SLOT_TX_NXT;

  // Start conditions: enabled, ready and a nonzero current count
  // Receive is tested first so incoming data is never overrun by transmit
  assign rx_go = rx_en_q & rx_ready & (cnt_q[rx_cur] != CNT_ZERO) & (~hd | ~mode.half_tx);
  assign tx_go = tx_en_q & tx_ready & (cnt_q[tx_cur] != CNT_ZERO) & (~hd | mode.half_tx);

  // Unit completion and end-of-buffer detection
  // A count of one at the grant edge means this unit empties the buffer
  assign unit_done = (state_q != ST_IDLE) & mem_grant;
  assign reach_zero = unit_done & (cnt_q[cur_q] == CNT_ONE);
  assign stop_now = reach_zero & (cnt_q[nxt_q] == CNT_ZERO);
  assign done_rx = state_q == ST_RX_STORE;
  assign done_tx = state_q == ST_TX_FETCH;

  // Transfer engine: one unit at a time, receive served first
  // The request is frozen until granted, so pointer writes apply to the next unit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cur_q <= SLOT_RX_CUR;
      nxt_q <= SLOT_RX_NXT;
      unit_q <= UNIT_BYTE;
      mem_req_q <= '0;
      rx_take_q <= 1'b0;
    end else begin
      rx_take_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          unit_q <= mode.size;
          if (rx_go) begin
            rx_take_q <= 1'b1;
            cur_q <= rx_cur;
            nxt_q <= rx_nxt;
            mem_req_q.valid <= 1'b1;
            mem_req_q.write <= 1'b1;
            mem_req_q.size <= mode.size;
            mem_req_q.addr <= ptr_q[rx_cur];
            mem_req_q.wdata <= rx_hold_data;
            state_q <= ST_RX_STORE;
          end else if (tx_go) begin
            cur_q <= tx_cur;
            nxt_q <= tx_nxt;
            mem_req_q.valid <= 1'b1;
            mem_req_q.write <= 1'b0;
            mem_req_q.size <= mode.size;
            mem_req_q.addr <= ptr_q[tx_cur];
            state_q <= ST_TX_FETCH;
          end
        end
        ST_RX_STORE, ST_TX_FETCH: begin
          if (mem_grant) begin
            mem_req_q.valid <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          mem_req_q.valid <= 1'b0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Transmit holding register load from fetched memory data
  // Read data only stands in the grant cycle, so it is captured there
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_load_q <= 1'b0;
      tx_data_q <= RESET_WORD;
    end else begin
      tx_load_q <= unit_done & done_tx;
      if (unit_done & done_tx) begin
        tx_data_q <= mem_rdata;
      end
    end
  end

  // Pointer and counter storage; a software write wins over the engine
  // Chaining and stepping both key off the grant edge of the unit in flight
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SLOT_NUM; i++) begin
        ptr_q[i] <= RESET_WORD;
        cnt_q[i] <= CNT_ZERO;
      end
    end else begin
      if (unit_done) begin
        if (reach_zero && cnt_q[nxt_q] != CNT_ZERO) begin
          ptr_q[cur_q] <= ptr_q[nxt_q];
          cnt_q[cur_q] <= cnt_q[nxt_q];
          ptr_q[nxt_q] <= RESET_WORD;
          cnt_q[nxt_q] <= CNT_ZERO;
        end else begin
          ptr_q[cur_q] <= ptr_q[cur_q] + unit_step(unit_q);
          if (cnt_q[cur_q] != CNT_ZERO) begin
            cnt_q[cur_q] <= cnt_q[cur_q] - CNT_ONE;
          end
        end
      end
      if (reg_wr) begin
        if (paddr[KIND_BIT]) begin
          cnt_q[wr_slot] <= pwdata[CNT_W-1:0];
        end else begin
          ptr_q[wr_slot] <= pwdata;
        end
      end
    end
  end

  // Completion flags; a set in the same cycle as a clear wins
  // Receive full clears on transmit count writes, matching the documented map
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags_q <= '0;
    end else begin
      flags_q.end_rx <= (reach_zero & done_rx) | (flags_q.end_rx & ~clr_rx_end);
      flags_q.end_tx <= (reach_zero & done_tx) | (flags_q.end_tx & ~clr_tx_side);
      flags_q.rx_full <= (stop_now & done_rx) | (flags_q.rx_full & ~clr_tx_side);
      flags_q.tx_empty <= (stop_now & done_tx) | (flags_q.tx_empty & ~clr_tx_side);
    end
  end

  // Outputs straight from flip-flops
  // No logic sits between these registers and the pins
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rx_hold_take = rx_take_q;
  assign tx_hold_data = tx_data_q;
  assign tx_hold_load = tx_load_q;
  assign flags = flags_q;
  assign mem_req = mem_req_q;

endmodule : peripheral_dma_channel_pair

`default_nettype wire

/* rtl/dma_pkg.sv */
// Shared constants and carriers for the peripheral DMA channel pair.
// Assumes a 12-bit peripheral-local APB address and a 32-bit system bus.
package dma_pkg;

  // APB address width inside the served peripheral's space
  localparam int unsigned APB_AW = 12;
  localparam int unsigned DATA_W = 32;

  // Register offsets (byte addresses)
  localparam logic [11:0] OFS_RX_PTR = 12'h100;
  localparam logic [11:0] OFS_RX_CNT = 12'h104;
  localparam logic [11:0] OFS_TX_PTR = 12'h108;
  localparam logic [11:0] OFS_TX_CNT = 12'h10C;
  localparam logic [11:0] OFS_RX_NPTR = 12'h110;
  localparam logic [11:0] OFS_RX_NCNT = 12'h114;
  localparam logic [11:0] OFS_TX_NPTR = 12'h118;
  localparam logic [11:0] OFS_TX_NCNT = 12'h11C;
  localparam logic [11:0] OFS_CTL = 12'h120;
  localparam logic [11:0] OFS_STATE = 12'h124;

  // Pointer/counter slot decode: bit 2 picks counter, bits 4:3 pick the slot
  localparam int unsigned KIND_BIT = 2;
  localparam int unsigned SLOT_LSB = 3;
  localparam int unsigned SLOT_MSB = 4;
  localparam logic [1:0] SLOT_RX_CUR = 2'h0;
  localparam logic [1:0] SLOT_TX_CUR = 2'h1;
  localparam logic [1:0] SLOT_RX_NXT = 2'h2;
  localparam logic [1:0] SLOT_TX_NXT = 2'h3;
  localparam int unsigned SLOT_NUM = 4;

  // Control register command bits
  localparam int unsigned CTL_RX_ON = 0;
  localparam int unsigned CTL_RX_OFF = 1;
  localparam int unsigned CTL_TX_ON = 8;
  localparam int unsigned CTL_TX_OFF = 9;

  // State register bits
  localparam int unsigned STS_RX_EN = 0;
  localparam int unsigned STS_TX_EN = 8;
  localparam int unsigned STS_END_RX = 16;
  localparam int unsigned STS_END_TX = 17;
  localparam int unsigned STS_RX_FULL = 18;
  localparam int unsigned STS_TX_EMPTY = 19;

  // Pointer increments per unit
  localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] STEP_HALF = 32'h0000_0002;
  localparam logic [31:0] STEP_WORD = 32'h0000_0004;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {UNIT_BYTE, UNIT_HALF, UNIT_WORD} unit_type;

  // Request to the bus matrix, held until granted
  typedef struct packed {
    logic valid;
    logic write;
    unit_type size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_type;

  // Operating mode supplied by the served peripheral
  typedef struct packed {
    logic half_duplex;
    logic half_tx;
    unit_type size;
  } served_peripheral_prefix_mode_type;

  // Flags returned to the served peripheral
  typedef struct packed {
    logic end_rx;
    logic end_tx;
    logic rx_full;
    logic tx_empty;
  } flags_type;

endpackage : dma_pkg

/* testbench/dma_checker_assertions.sv */
// Port checker for the DMA channel pair, bound to the top module.
// Assumes one clock mclk and the active-high reset rst.
`timescale 1ns/1ps
`default_nettype none
module dma_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [dma_pkg::DATA_W-1:0] prdata,
  input wire logic rx_hold_take,
  input wire logic tx_hold_load,
  input wire logic [dma_pkg::DATA_W-1:0] tx_hold_data,
  input wire dma_pkg::flags_type flags,
  input wire dma_pkg::mem_req_type mem_req,
  input wire logic mem_grant,
  input wire logic [dma_pkg::DATA_W-1:0] mem_rdata,
  input wire dma_pkg::served_peripheral_prefix_mode_type mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Register bus answers once, right after setup
  apb_answer_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  pready_once_a: assert property (pready |=> !pready) else $error("answer longer than one cycle");
  idle_rdata_a: assert property (!pready |-> prdata == '0) else $error("read data outside answer");
  // Matrix request held until granted, then withdrawn
  req_hold_a: assert property (mem_req.valid && !mem_grant |=> $stable(mem_req)) else $error("request moved");
  grant_drop_a: assert property (mem_req.valid && mem_grant |=> !mem_req.valid) else $error("request kept");
  take_write_a: assert property (rx_hold_take |-> mem_req.valid && mem_req.write) else $error("take without write");
  take_size_a: assert property (rx_hold_take |-> mem_req.size == $past(mode.size)) else $error("wrong access size");
  // Holding register loaded with what the matrix returned
  load_data_a: assert property (tx_hold_load |-> $past(mem_grant) && !$past(mem_req.write)
    && tx_hold_data == $past(mem_rdata)) else $error("bad transmit load");
  // Receive end flag only drops on a register write
  end_clear_a: assert property ($fell(flags.end_rx) |-> $past(pwrite) && $past(penable))
    else $error("end flag lost");
endmodule : dma_checker
bind peripheral_dma_channel_pair dma_checker chk_i (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .prdata(prdata), .rx_hold_take(rx_hold_take), .tx_hold_load(tx_hold_load),
  .tx_hold_data(tx_hold_data), .flags(flags), .mem_req(mem_req), .mem_grant(mem_grant), .mem_rdata(mem_rdata),
  .mode(mode));
`default_nettype wire

/* testbench/matrix_model.sv */
// Bus matrix model: grants a held request after a set wait, logs it.
// Assumes requests arrive on mclk and stay held until granted.
`timescale 1ns/1ps
`default_nettype none
module matrix_model (
  input wire logic mclk,
  input wire logic rst,
  input wire dma_pkg::mem_req_type mem_req,
  input wire logic [3:0] wait_cycles,
  output logic mem_grant,
  output logic [31:0] mem_rdata,
  output logic [31:0] seen_addr,
  output logic [31:0] seen_data
);
  import dma_pkg::*;
  logic [3:0] wait_q;
  logic [31:0] noise_q;
  // Read data only valid in the grant cycle, noise otherwise
  assign mem_rdata = mem_grant ? ~mem_req.addr : noise_q;
  // Wait, grant one cycle, log the access at the grant edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wait_q <= 4'h0;
      mem_grant <= 1'b0;
      noise_q <= 32'h0;
      seen_addr <= 32'h0;
      seen_data <= 32'h0;
    end else begin
      noise_q <= noise_q + 32'h9E37_79B9;
      mem_grant <= 1'b0;
      if (mem_grant) begin
        seen_addr <= mem_req.addr;
        seen_data <= mem_req.write ? mem_req.wdata : mem_rdata;
      end else if (mem_req.valid) begin
        if (wait_q >= wait_cycles) begin
          mem_grant <= 1'b1;
          wait_q <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule : matrix_model
`default_nettype wire

/* testbench/peripheral_dma_channel_pair_bench.sv */
// Testbench for the DMA channel pair: APB tasks plus peripheral units.
// Assumes the matrix model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module peripheral_dma_channel_pair_bench;
  import dma_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rx_hold_data = 32'h0, rd_q;
  logic rx_ready = 1'b0, tx_ready = 1'b0, err_q;
  logic [3:0] wait_cycles = 4'h3;
  served_peripheral_prefix_mode_type mode = '{1'b0, 1'b0, UNIT_WORD};
  logic [31:0] prdata, tx_hold_data, mem_rdata, seen_addr, seen_data;
  logic pready, pslverr, rx_hold_take, tx_hold_load, mem_grant;
  flags_type flags;
  mem_req_type mem_req;
  int errors = 0, total_checks = 0, cycles = 0;
  peripheral_dma_channel_pair dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode(mode),
    .rx_ready(rx_ready), .rx_hold_data(rx_hold_data), .rx_hold_take(rx_hold_take), .tx_ready(tx_ready),
    .tx_hold_data(tx_hold_data), .tx_hold_load(tx_hold_load), .flags(flags), .mem_req(mem_req),
    .mem_grant(mem_grant), .mem_rdata(mem_rdata));
  matrix_model mm (.mclk(mclk), .rst(rst), .mem_req(mem_req), .wait_cycles(wait_cycles),
    .mem_grant(mem_grant), .mem_rdata(mem_rdata), .seen_addr(seen_addr), .seen_data(seen_data));
  always #20 mclk = ~mclk;
  // Cut a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    // Let the written value settle before anything looks at it
    @(posedge mclk);
  endtask : wr
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd_q);
  endtask : rd
  // Receive unit: present data, drop ready on take, wait for the grant
  task automatic rx_unit(input logic [31:0] d);
    @(posedge mclk);
    rx_ready <= 1'b1;
    rx_hold_data <= d;
    do @(posedge mclk); while (rx_hold_take !== 1'b1);
    rx_ready <= 1'b0;
    rx_hold_data <= ~d;
    do @(posedge mclk); while (mem_grant !== 1'b1);
    @(posedge mclk);
  endtask : rx_unit
  // Transmit unit: ask, drop ready at the grant, check fetched data on load
  task automatic tx_unit();
    @(posedge mclk);
    tx_ready <= 1'b1;
    do @(posedge mclk); while (mem_grant !== 1'b1);
    tx_ready <= 1'b0;
    do @(posedge mclk); while (tx_hold_load !== 1'b1);
    chk("tx data", ~seen_addr, tx_hold_data);
  endtask : tx_unit
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) rd("reset", 12'h100 + 12'(4 * i), 32'h0);
    apb(1'b0, 12'h128, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err_q});
    wr(OFS_RX_PTR, 32'h1000);
    wr(OFS_RX_CNT, 32'h2);
    wr(OFS_RX_NPTR, 32'h2000);
    wr(OFS_RX_NCNT, 32'h1);
    wr(OFS_CTL, 32'h1);
    rd("rx on", OFS_STATE, 32'h1);
    rx_unit(32'h11);
    chk("rx addr", 32'h1000, seen_addr);
    chk("rx data", 32'h11, seen_data);
    rd("rx count", OFS_RX_CNT, 32'h1);
    rd("rx ptr", OFS_RX_PTR, 32'h1004);
    wr(OFS_RX_PTR, 32'h3000);
    rx_unit(32'h22);
    chk("new addr", 32'h3000, seen_addr);
    rd("chain ptr", OFS_RX_PTR, 32'h2000);
    rd("chain count", OFS_RX_CNT, 32'h1);
    rd("next zero", OFS_RX_NCNT, 32'h0);
    chk("flags", 32'h8, {28'h0, flags});
    rx_unit(32'h33);
    chk("last addr", 32'h2000, seen_addr);
    chk("flags", 32'hA, {28'h0, flags});
    @(posedge mclk);
    rx_ready <= 1'b1;
    repeat (8) @(posedge mclk);
    rx_ready <= 1'b0;
    rd("halted", OFS_RX_PTR, 32'h2004);
    wr(OFS_RX_CNT, 32'h0);
    chk("flags", 32'hA, {28'h0, flags});
    wr(OFS_RX_NCNT, 32'h1);
    chk("flags", 32'h2, {28'h0, flags});
    wr(OFS_TX_NCNT, 32'h1);
    chk("flags", 32'h0, {28'h0, flags});
    wr(OFS_CTL, 32'h103);
    rd("off wins", OFS_STATE, 32'h100);
    wait_cycles <= 4'h0;
    mode.size <= UNIT_HALF;
    wr(OFS_TX_PTR, 32'h4000);
    wr(OFS_TX_NPTR, 32'h5000);
    wr(OFS_TX_CNT, 32'h2);
    tx_unit();
    mode.size <= UNIT_BYTE;
    tx_unit();
    chk("half step", 32'h4002, seen_addr);
    chk("flags", 32'h4, {28'h0, flags});
    tx_unit();
    chk("chain addr", 32'h5000, seen_addr);
    rd("byte step", OFS_TX_PTR, 32'h5001);
    chk("flags", 32'h5, {28'h0, flags});
    mode.half_duplex <= 1'b1;
    wr(OFS_TX_CNT, 32'h5);
    chk("flags", 32'h0, {28'h0, flags});
    rd("shared count", OFS_RX_CNT, 32'h5);
    wr(OFS_TX_PTR, 32'h6000);
    rd("shared ptr", OFS_RX_PTR, 32'h6000);
    conclude();
  end
endmodule : peripheral_dma_channel_pair_bench
`default_nettype wire
